// file: include/swl_regs.svh
// timing and command constants of the single-wire command link master
`ifndef SWL_REGS_SVH
`define SWL_REGS_SVH
`define SWL_CLK_MHZ 100
`define SWL_CNT_W 27
`define SWL_RST_LOW_US 480
`define SWL_RST_RX_US 480
`define SWL_PRES_SAMPLE_US 70
`define SWL_SLOT_US 70
`define SWL_W1_LOW_US 2
`define SWL_W1_MAX_US 15
`define SWL_SAMPLE_US 12
`define SWL_REC_US 2
`define SWL_COPY_HOLD_US 10000
`define SWL_CONV_HOLD_US 1000000
`define SWL_CMD_CONVERT 8'h44
`define SWL_BIT_LAST 3'h7
`define SWL_BIT_FIRST 3'h0
`endif

// file: include/swl_pkg.sv
// types of the single-wire command link master
`include "swl_regs.svh"
package swl_pkg;
    typedef logic [`SWL_CNT_W-1:0] swl_cnt_t;
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h0,
        ST_RST_LOW = 3'h1,
        ST_RST_RX = 3'h3,
        ST_SLOT = 3'h2,
        ST_RECOVER = 3'h6,
        ST_SPU = 3'h7
    } swl_state_t;
    typedef struct packed {
        logic sync1;
        logic sync2;
        swl_state_t st;
        swl_cnt_t cnt;
        logic [2:0] bit_idx;
        logic tx_bit;
        logic [7:0] shreg;
        logic spu_req;
        logic spu_long;
        logic rsp_valid;
        logic [7:0] rsp_data;
        logic presence;
        logic dq_oe;
        logic spu_oe;
    } swl_regs_t;
endpackage

// file: rtl/swl_master.sv
// single-wire command link master: reset/presence, byte slots, strong pull-up
`timescale 1ns/1ns
`default_nettype none
`include "swl_regs.svh"
module swl_master #(
    parameter int unsigned RST_LOW_CYC = `SWL_RST_LOW_US * `SWL_CLK_MHZ,
    parameter int unsigned RST_RX_CYC = `SWL_RST_RX_US * `SWL_CLK_MHZ,
    parameter int unsigned COPY_HOLD_CYC = `SWL_COPY_HOLD_US * `SWL_CLK_MHZ,
    parameter int unsigned CONV_HOLD_CYC = `SWL_CONV_HOLD_US * `SWL_CLK_MHZ
)(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_reset,
    input wire logic cmd_single,
    input wire logic cmd_spu,
    input wire logic [7:0] cmd_data,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_presence,
    input wire logic dq_in,
    output logic dq_out,
    output logic dq_oe,
    output logic spu_oe
);
    import swl_pkg::*;

    // ==========================================================
    // timing
    localparam int unsigned SLOT_CYC = `SWL_SLOT_US * `SWL_CLK_MHZ;
    localparam int unsigned W1_LOW_CYC = `SWL_W1_LOW_US * `SWL_CLK_MHZ;
    localparam int unsigned W1_MAX_CYC = `SWL_W1_MAX_US * `SWL_CLK_MHZ;
    localparam int unsigned SAMPLE_CYC = `SWL_SAMPLE_US * `SWL_CLK_MHZ;
    localparam int unsigned REC_CYC = `SWL_REC_US * `SWL_CLK_MHZ;
    localparam int unsigned PRES_CYC = `SWL_PRES_SAMPLE_US * `SWL_CLK_MHZ;
    localparam swl_cnt_t RST_LOW_END = swl_cnt_t'(RST_LOW_CYC - 1);
    localparam swl_cnt_t RST_RX_END = swl_cnt_t'(RST_RX_CYC - 1);
    localparam swl_cnt_t PRES_AT = swl_cnt_t'(PRES_CYC - 1);
    localparam swl_cnt_t SLOT_END = swl_cnt_t'(SLOT_CYC - 1);
    localparam swl_cnt_t W1_LOW_END = swl_cnt_t'(W1_LOW_CYC - 1);
    localparam swl_cnt_t W1_MAX_END = swl_cnt_t'(W1_MAX_CYC - 1);
    localparam swl_cnt_t SAMPLE_AT = swl_cnt_t'(SAMPLE_CYC - 1);
    localparam swl_cnt_t REC_END = swl_cnt_t'(REC_CYC - 1);
    localparam swl_cnt_t COPY_END = swl_cnt_t'(COPY_HOLD_CYC - 1);
    localparam swl_cnt_t CONV_END = swl_cnt_t'(CONV_HOLD_CYC - 1);

    swl_regs_t r;
    swl_regs_t next_r;

    // ==========================================================
    // sequencer
    always_comb
    begin
        next_r = r;
        next_r.sync1 = dq_in;
        next_r.sync2 = r.sync1;
        next_r.rsp_valid = 1'b0;
        next_r.cnt = r.cnt + swl_cnt_t'(1);
        unique case (r.st)
            ST_IDLE:
            begin
                next_r.cnt = '0;
                if (cmd_valid)
                begin
                    next_r.dq_oe = 1'b1;
                    if (cmd_reset)
                    begin
                        // a reset between bytes also aborts a running read
                        // never taken inside a byte, so write data is not cut
                        next_r.st = ST_RST_LOW;
                    end
                    else
                    begin
                        next_r.st = ST_SLOT;
                        next_r.tx_bit = cmd_data[0];
                        next_r.shreg = cmd_data;
                        next_r.bit_idx = cmd_single ? `SWL_BIT_LAST : `SWL_BIT_FIRST;
                        next_r.spu_req = cmd_spu;
                        next_r.spu_long = (cmd_data == `SWL_CMD_CONVERT);
                    end
                end
            end
            ST_RST_LOW:
            begin
                if (r.cnt == RST_LOW_END)
                begin
                    next_r.st = ST_RST_RX;
                    next_r.cnt = '0;
                    next_r.dq_oe = 1'b0;
                end
            end
            ST_RST_RX:
            begin
                // sensor low window always covers this point
                if (r.cnt == PRES_AT)
                begin
                    next_r.presence = ~r.sync2;
                end
                if (r.cnt == RST_RX_END)
                begin
                    next_r.st = ST_IDLE;
                    next_r.rsp_valid = 1'b1;
                end
            end
            ST_SLOT:
            begin
                // a one, or a read, is a short low; a zero stays low all slot
                if (r.tx_bit && r.cnt == W1_LOW_END)
                begin
                    next_r.dq_oe = 1'b0;
                end
                if (r.cnt == SAMPLE_AT)
                begin
                    next_r.shreg = {r.sync2, r.shreg[7:1]};
                end
                if (r.cnt == SLOT_END)
                begin
                    next_r.st = ST_RECOVER;
                    next_r.cnt = '0;
                    next_r.dq_oe = 1'b0;
                end
            end
            ST_RECOVER:
            begin
                if (r.cnt == REC_END)
                begin
                    next_r.cnt = '0;
                    if (r.bit_idx == `SWL_BIT_LAST)
                    begin
                        next_r.rsp_valid = 1'b1;
                        next_r.rsp_data = r.shreg;
                        // pull-up comes at once, far inside 10 us
                        next_r.st = r.spu_req ? ST_SPU : ST_IDLE;
                        next_r.spu_oe = r.spu_req;
                    end
                    else
                    begin
                        next_r.st = ST_SLOT;
                        next_r.bit_idx = r.bit_idx + 3'h1;
                        next_r.tx_bit = r.shreg[0];
                        next_r.dq_oe = 1'b1;
                    end
                end
            end
            ST_SPU:
            begin
                // bus stays silent until the hold is over
                if (r.cnt == (r.spu_long ? CONV_END : COPY_END))
                begin
                    next_r.st = ST_IDLE;
                    next_r.spu_oe = 1'b0;
                end
            end
            default:
            begin
                // unused codes fall back to idle rather than lock up
                next_r.st = ST_IDLE;
                next_r.dq_oe = 1'b0;
                next_r.spu_oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign cmd_ready = (r.st == ST_IDLE);
    assign rsp_valid = r.rsp_valid;
    assign rsp_data = r.rsp_data;
    assign rsp_presence = r.presence;
    assign dq_out = 1'b0;
    assign dq_oe = r.dq_oe;
    assign spu_oe = r.spu_oe;

    // ==========================================================
    // checks
    swl_cnt_t run;

    always_ff @(posedge clk)
    begin
        if (sys_rst || next_r.st != r.st)
        begin
            run <= '0;
        end
        else
        begin
            run <= run + swl_cnt_t'(1);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_byte_accept;
        cmd_valid && cmd_ready && !cmd_reset;
    endsequence

    sequence s_reset_accept;
        cmd_valid && cmd_ready && cmd_reset;
    endsequence

    sequence s_left_slot;
        r.st == ST_RECOVER && $past(r.st) == ST_SLOT;
    endsequence

    rst_low_len_a: assert property (
        (r.st == ST_RST_RX && $past(r.st) == ST_RST_LOW) |-> $past(run) == RST_LOW_END)
        else $error("reset pulse length wrong");

    rst_listen_a: assert property (
        (r.st == ST_RST_RX) |-> !r.dq_oe)
        else $error("line driven while listening for presence");

    abort_reset_a: assert property (
        s_reset_accept |=> (r.st == ST_RST_LOW && r.dq_oe) ##1 r.dq_oe)
        else $error("reset request did not start a reset pulse");

    slot_len_a: assert property (
        s_left_slot |-> $past(run) == SLOT_END)
        else $error("time slot length wrong");

    recov_len_a: assert property (
        (r.st == ST_SLOT && $past(r.st) == ST_RECOVER) |->
            $past(run) == REC_END && !$past(r.dq_oe))
        else $error("recovery between slots wrong");

    one_release_a: assert property (
        ($fell(r.dq_oe) && r.st == ST_SLOT) |->
            $past(r.tx_bit) && $past(run) == W1_LOW_END && W1_LOW_END < W1_MAX_END)
        else $error("one or read slot low time wrong");

    zero_hold_a: assert property (
        (s_left_slot ##0 !$past(r.tx_bit)) |-> $past(r.dq_oe, 2) && $past(r.dq_oe))
        else $error("zero slot released early");

    lsb_first_a: assert property (
        s_byte_accept |=> r.tx_bit == $past(cmd_data[0]) && r.st == ST_SLOT)
        else $error("first bit is not the least significant");

    spu_on_a: assert property (
        $rose(r.spu_oe) |-> $past(r.st) == ST_RECOVER && $past(r.spu_req) && r.rsp_valid)
        else $error("strong pull-up not right after the byte");

    spu_hold_a: assert property (
        $fell(r.spu_oe) |-> $past(run) >= COPY_END)
        else $error("strong pull-up released too soon");

    spu_quiet_a: assert property (
        r.spu_oe |-> !r.dq_oe && !cmd_ready)
        else $error("bus activity during strong pull-up");
endmodule
`default_nettype wire

// file: verification/swl_sensor_model.sv
// behavioural single-wire temperature sensor facing the link master
`timescale 1ns/1ns
`default_nettype none
module swl_sensor_model #(
    parameter int RST_MIN_NS = 80000,
    parameter bit EXT_SUPPLY = 1'b1,
    parameter int BUSY_NS = 100000,
    parameter logic [15:0] TEMP = 16'h012A
)(
    input wire logic line,
    output logic pull
);
    // ==========
    // workspace, nonvolatile limits and slot state
    logic [8:0][7:0] ws = '0;
    logic [1:0][7:0] nv = 16'h464B;
    logic [7:0] rx = 8'h00;
    logic busy = 1'b0;
    int nbit = 0;
    int phase = 7;
    int rbyte = 0;
    int t;
    initial
    begin
        pull = 1'b0;
        ws[3:2] = 16'h464B;
    end
    // ==========
    // byte decode; data moves at once, only the busy flag is timed
    task automatic take_byte();
        if (phase == 0)
            phase = (rx == 8'hCC) ? 1 : 7;
        else if (phase != 1)
        begin
            ws[phase] = rx;
            phase = (phase == 2) ? 3 : 7;
        end
        else
        begin
            phase = (rx == 8'h4E) ? 2 : (rx == 8'hBE) ? 4 : (rx == 8'hB4) ? 6 : 7;
            if (rx == 8'h48)
                nv = ws[3:2];
            if (rx == 8'h44)
                ws[1:0] = TEMP;
            if (rx == 8'hB8)
                ws[3:2] = nv;
            if (rx == 8'h44 || rx == 8'hB8)
            begin
                busy = 1'b1;
                phase = 5;
                fork
                    #BUSY_NS busy = 1'b0;
                join_none
            end
        end
    endtask
    // ==========
    // each slot timed from the fall; ideal sampling, no metastability
    always
    begin
        @(negedge line);
        if (phase == 4)
            pull = !ws[rbyte][nbit];
        else if (phase == 5 || phase == 6)
            pull = (phase == 5) ? busy : !EXT_SUPPLY;
        #15000 pull = 1'b0;
        #15000 rx = {line, rx[7:1]};
        for (t = 30000; line === 1'b0 && t < RST_MIN_NS; t += 1000)
            #1000;
        if (line === 1'b0)
        begin
            phase = 0;
            nbit = 0;
            rbyte = 0;
            wait (line !== 1'b0);
            #20000 pull = 1'b1;
            #60000 pull = 1'b0;
        end
        else if (phase == 4)
        begin
            rbyte = (nbit == 7) ? (rbyte + 1) % 9 : rbyte;
            nbit = (nbit + 1) % 8;
        end
        else if (phase < 4 && nbit < 7)
            nbit++;
        else if (phase < 4)
        begin
            nbit = 0;
            take_byte();
        end
    end
endmodule
`default_nettype wire

// file: verification/swl_master_test.sv
// self-checking bench of the link master against the sensor model
`timescale 1ns/1ns
`default_nettype none
module swl_master_test;
    // ==========
    // scaled counts; the reset pulse must outlast a zero slot
    localparam int RST_LOW = 10000;
    localparam int RST_RX = 9000;
    localparam int COPY_HOLD = 500;
    localparam int CONV_HOLD = 1000;
    localparam logic [15:0] TEMP = 16'h012A;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_reset = 1'b0;
    logic cmd_single = 1'b0;
    logic cmd_spu = 1'b0;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_ready, rsp_valid, rsp_presence, dq_out, dq_oe, spu_oe, pull;
    logic [7:0] rsp_data;
    wire line;
    int fail_count = 0;
    int samples_checked = 0;
    int n, lows, hold, busy_ready;
    always #5 clk = ~clk;
    // open drain with pull-up: low while either end pulls
    assign line = ((dq_oe === 1'b1 && dq_out === 1'b0) || pull === 1'b1) ? 1'b0 : 1'b1;
    swl_master #(.RST_LOW_CYC(RST_LOW), .RST_RX_CYC(RST_RX), .COPY_HOLD_CYC(COPY_HOLD),
        .CONV_HOLD_CYC(CONV_HOLD)) dut_u (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_reset(cmd_reset), .cmd_single(cmd_single),
        .cmd_spu(cmd_spu), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_presence(rsp_presence), .dq_in(line), .dq_out(dq_out), .dq_oe(dq_oe),
        .spu_oe(spu_oe));
    swl_sensor_model #(.TEMP(TEMP)) sensor_u (.line(line), .pull(pull));
    // ==========
    // shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic req(input logic rst, single, spu, input logic [7:0] data);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_reset <= rst;
        cmd_single <= single;
        cmd_spu <= spu;
        cmd_data <= data;
        do
            @(negedge clk);
        while (cmd_ready !== 1'b1);
        @(posedge clk);
        cmd_valid <= 1'b0;
        n = 0;
        lows = 0;
        do
        begin
            @(negedge clk);
            n++;
            lows += int'(dq_oe === 1'b1);
        end
        while (rsp_valid !== 1'b1);
        hold = 0;
        busy_ready = 0;
        while (spu_oe === 1'b1)
        begin
            hold++;
            busy_ready += int'(cmd_ready === 1'b1);
            @(negedge clk);
        end
    endtask
    task automatic send(input logic [7:0] b);
        req(1'b0, 1'b0, 1'b0, b);
    endtask
    task automatic init();
        req(1'b1, 1'b0, 1'b0, 8'h00);
        check({7'h00, rsp_presence}, 8'h01, "presence");
    endtask
    task automatic address();
        init();
        send(8'hCC);
    endtask
    task automatic poll_done(input string what);
        req(1'b0, 1'b1, 1'b0, 8'hFF);
        check({7'h00, rsp_data[7]}, 8'h00, what);
        for (int k = 0; k < 6 && rsp_data[7] !== 1'b1; k++)
            req(1'b0, 1'b1, 1'b0, 8'hFF);
        check({7'h00, rsp_data[7]}, 8'h01, what);
    endtask
    // ==========
    // scenarios
    task automatic t_init();
        init();
        check({7'h00, lows == RST_LOW}, 8'h01, "reset low time");
        check({7'h00, dq_out}, 8'h00, "open-drain drive level");
        check({7'h00, n >= RST_LOW + RST_RX && n <= RST_LOW + RST_RX + 3}, 8'h01, "init span");
        $display("test init done");
    endtask
    task automatic t_convert();
        address();
        req(1'b0, 1'b0, 1'b1, 8'h44);
        check({7'h00, hold == CONV_HOLD}, 8'h01, "conversion pull-up");
        address();
        send(8'h44);
        poll_done("conversion status");
        $display("test convert done");
    endtask
    task automatic t_write_copy();
        address();
        send(8'h4E);
        send(8'hA5);
        send(8'h3C);
        address();
        req(1'b0, 1'b0, 1'b1, 8'h48);
        check({7'h00, hold == COPY_HOLD}, 8'h01, "copy pull-up");
        check({7'h00, busy_ready == 0}, 8'h01, "quiet under pull-up");
        $display("test write and copy done");
    endtask
    task automatic t_recall_read();
        logic [7:0] exp [4];
        exp = '{TEMP[7:0], TEMP[15:8], 8'hA5, 8'h3C};
        address();
        send(8'h4E);
        send(8'h00);
        send(8'h00);
        address();
        send(8'hB8);
        poll_done("reload status");
        address();
        send(8'hBE);
        for (int k = 0; k < 4; k++)
        begin
            send(8'hFF);
            check(rsp_data, exp[k], "workspace byte");
        end
        init();
        $display("test reload and read done");
    endtask
    task automatic t_supply_unaddressed();
        address();
        send(8'hB4);
        req(1'b0, 1'b1, 1'b0, 8'hFF);
        check({7'h00, rsp_data[7]}, 8'h01, "supply mode");
        init();
        send(8'hBE);
        send(8'hFF);
        check(rsp_data, 8'hFF, "silent when unaddressed");
        $display("test supply and unaddressed done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        t_init();
        t_convert();
        t_write_copy();
        t_recall_read();
        t_supply_unaddressed();
        summarize();
    end
    // about 1.75 million cycles expected; the limit leaves margin
    initial
    begin
        repeat (3000000) @(posedge clk);
        fail_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        summarize();
    end
endmodule
`default_nettype wire
